// *** pkg/fpsm_pkg.sv ***
package fpsm_pkg;
    // Register offsets
    localparam logic [9:0] FPSM_ADDR_PRESCALER = 10'h016;
    localparam logic [9:0] FPSM_ADDR_STATUSSEL = 10'h017;
    localparam logic [9:0] FPSM_ADDR_PINGUARD  = 10'h01D;
    // Field positions
    localparam int FPSM_PRESC_LSB  = 0;
    localparam int FPSM_PRESC_MSB  = 2;
    localparam int FPSM_SEL_LSB    = 2;
    localparam int FPSM_SEL_MSB    = 7;
    localparam int FPSM_GUARD_BIT  = 7;
    // Reset values
    localparam logic [7:0] FPSM_PRESC_RST = 8'h06;
    localparam logic [7:0] FPSM_SEL_RST   = 8'h00;
    localparam logic [7:0] FPSM_GUARD_RST = 8'h00;
    // Prescaler codes
    localparam logic [2:0] FPSM_P_FD1  = 3'h0;
    localparam logic [2:0] FPSM_P_FD2  = 3'h1;
    localparam logic [2:0] FPSM_P_DM2  = 3'h2;
    localparam logic [2:0] FPSM_P_DM4  = 3'h3;
    localparam logic [2:0] FPSM_P_DM8  = 3'h4;
    localparam logic [2:0] FPSM_P_DM16 = 3'h5;
    localparam logic [2:0] FPSM_P_DM32 = 3'h6;
    localparam logic [2:0] FPSM_P_FD3  = 3'h7;
    // Status selector codes
    localparam logic [5:0] FPSM_S_GND    = 6'h00;
    localparam logic [5:0] FPSM_S_NDIV   = 6'h01;
    localparam logic [5:0] FPSM_S_RDIV   = 6'h02;
    localparam logic [5:0] FPSM_S_ADIV   = 6'h03;
    localparam logic [5:0] FPSM_S_PRESC  = 6'h04;
    localparam logic [5:0] FPSM_S_UP     = 6'h05;
    localparam logic [5:0] FPSM_S_DOWN   = 6'h06;
    localparam logic [5:0] FPSM_S_GND_HI = 6'h20;
endpackage : fpsm_pkg

// *** design/fpsm_top.sv ***
// Notes on behaviour
// - Codes 0,1: fixed divide by 1, 2
// - Code 2: divide 2/3, only 2 if A zero
// - Code 3: divide 4/5, only 4 if A zero
// - Code 4: divide 8/9, only 8 if A zero
// - Code 5: divide 16/17, only 16 if A zero
// - Code 6 default: divide 32/33, 32 if A zero
// - Selector 000001 routes delayed N divider output
// - Selector 000010 routes delayed R divider output
// - Selectors 3..6: A, prescaler, up, down
// - Other bit7-clear codes give static ground
// - Bit7 set uses shared decode; 100000 ground
`timescale 1ns/1ns
module fpsm_top (
    input  wire logic       clk_sys,      // Feedback and reference clock
    input  wire logic       reset_n,      // Async reset, active low
    input  wire logic       regWrEn,      // Register write strobe
    input  wire logic       regRdEn,      // Register read strobe
    input  wire logic [9:0] regAddr,      // Register address
    input  wire logic [7:0] regWrData,    // Register write data
    input  wire logic       aCountNonzero, // A counter holds nonzero value
    input  wire logic       nDivOut,      // N divider output after delay
    input  wire logic       rDivOut,      // R divider output after delay
    input  wire logic       aDivOut,      // A divider output
    input  wire logic       pdUpPulse,    // Phase detector up pulse
    input  wire logic       pdDownPulse,  // Phase detector down pulse
    input  wire logic       sharedSelOut, // Shared pin decoder result
    output logic [7:0]      regRdData,    // Register read data
    output logic            prescalerOut, // Prescaler output pulse
    output logic            statusPin,    // Status pin level
    output logic            dualModulusMode, // Prescaler in dual modulus
    output logic [5:0]      statusSelect  // Active status selection
);

    // Register state
    logic [7:0] prescReg_q;     // Prescaler register
    logic [7:0] prescReg_d;
    logic [7:0] selReg_q;       // Status select register
    logic [7:0] selReg_d;
    logic [7:0] guardReg_q;     // Guard register
    logic [7:0] guardReg_d;
    logic [7:0] rdData_q;       // Read data
    logic [7:0] rdData_d;

    // Divider state
    logic [5:0] divCnt_q;       // Cycles left in this period
    logic [5:0] divCnt_d;
    logic       extraNext_q;    // Next period uses the longer modulus
    logic       extraNext_d;
    logic       prescOut_q;     // Prescaler pulse
    logic       prescOut_d;
    logic       dmMode_q;       // Dual modulus indicator
    logic       dmMode_d;

    // Status output state
    logic       status_q;       // Status pin level
    logic       status_d;

    logic [2:0] prescCode;      // Active prescaler code
    logic [5:0] selCode;        // Active status code
    logic [5:0] baseRatio;      // Modulus P
    logic       dualMod;        // Dual modulus selected

    localparam int FPSM_PRESC_MSB_W = fpsm_pkg::FPSM_PRESC_MSB;

    assign prescCode = prescReg_q[FPSM_PRESC_MSB_W:0];
    assign selCode   = selReg_q[fpsm_pkg::FPSM_SEL_MSB:fpsm_pkg::FPSM_SEL_LSB];

    // Register writes and reads
    always_comb begin
        prescReg_d = prescReg_q;
        selReg_d   = selReg_q;
        guardReg_d = guardReg_q;
        rdData_d   = rdData_q;
        if (regWrEn) begin
            unique case (regAddr)
                // Prescaler field only, upper bits belong elsewhere
                fpsm_pkg::FPSM_ADDR_PRESCALER: begin
                    prescReg_d = {5'h00, regWrData[2:0]};
                end
                fpsm_pkg::FPSM_ADDR_STATUSSEL: begin
                    if (!guardReg_q[fpsm_pkg::FPSM_GUARD_BIT]) begin
                        selReg_d = {regWrData[7:2], 2'h0};
                    end
                end
                // Guard bit register
                fpsm_pkg::FPSM_ADDR_PINGUARD: begin
                    guardReg_d = regWrData;
                end
                // Unmapped writes ignored
                default: begin
                end
            endcase
        end
        if (regRdEn) begin
            unique case (regAddr)
                fpsm_pkg::FPSM_ADDR_PRESCALER: rdData_d = prescReg_q;
                fpsm_pkg::FPSM_ADDR_STATUSSEL: rdData_d = selReg_q;
                fpsm_pkg::FPSM_ADDR_PINGUARD:  rdData_d = guardReg_q;
                // Unmapped reads return zero
                default: rdData_d = 8'h00;
            endcase
        end
    end

    // Register storage
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prescReg_q <= fpsm_pkg::FPSM_PRESC_RST;
            selReg_q   <= fpsm_pkg::FPSM_SEL_RST;
            guardReg_q <= fpsm_pkg::FPSM_GUARD_RST;
            rdData_q   <= 8'h00;
        end else begin
            prescReg_q <= prescReg_d;
            selReg_q   <= selReg_d;
            guardReg_q <= guardReg_d;
            rdData_q   <= rdData_d;
        end
    end

    // Modulus decode
    always_comb begin
        baseRatio = 6'h01;
        dualMod   = 1'b0;
        unique case (prescCode)
            fpsm_pkg::FPSM_P_FD1:  baseRatio = 6'h01;
            fpsm_pkg::FPSM_P_FD2:  baseRatio = 6'h02;
            fpsm_pkg::FPSM_P_DM2:  begin baseRatio = 6'h02; dualMod = 1'b1; end
            fpsm_pkg::FPSM_P_DM4:  begin baseRatio = 6'h04; dualMod = 1'b1; end
            fpsm_pkg::FPSM_P_DM8:  begin baseRatio = 6'h08; dualMod = 1'b1; end
            fpsm_pkg::FPSM_P_DM16: begin baseRatio = 6'h10; dualMod = 1'b1; end
            fpsm_pkg::FPSM_P_DM32: begin baseRatio = 6'h20; dualMod = 1'b1; end
            fpsm_pkg::FPSM_P_FD3:  baseRatio = 6'h03;
        endcase
    end

    // Prescaler counter next state
    always_comb begin
        divCnt_d    = divCnt_q;
        extraNext_d = extraNext_q;
        prescOut_d  = 1'b0;
        dmMode_d    = dualMod;
        if (divCnt_q <= 6'h01) begin
            // Period ends, emit pulse and load next length
            prescOut_d = 1'b1;
            if (dualMod && aCountNonzero && extraNext_q) begin
                divCnt_d = baseRatio + 6'h01;
            end else begin
                divCnt_d = baseRatio;
            end
            extraNext_d = dualMod && aCountNonzero && !extraNext_q;
        end else begin
            divCnt_d = divCnt_q - 6'h01;
        end
    end

    // Prescaler counter storage
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_q    <= 6'h00;
            extraNext_q <= 1'b0;
            prescOut_q  <= 1'b0;
            dmMode_q    <= 1'b0;
        end else begin
            divCnt_q    <= divCnt_d;
            extraNext_q <= extraNext_d;
            prescOut_q  <= prescOut_d;
            dmMode_q    <= dmMode_d;
        end
    end

    // Status pin selection
    always_comb begin
        status_d = 1'b0;
        if (selCode[5]) begin
            // shared decode, ground code kept here
            status_d = (selCode == fpsm_pkg::FPSM_S_GND_HI) ? 1'b0 : sharedSelOut;
        end else begin
            unique case (selCode)
                fpsm_pkg::FPSM_S_NDIV:  status_d = nDivOut;
                fpsm_pkg::FPSM_S_RDIV:  status_d = rDivOut;
                fpsm_pkg::FPSM_S_ADIV:  status_d = aDivOut;
                fpsm_pkg::FPSM_S_PRESC: status_d = prescOut_q;
                fpsm_pkg::FPSM_S_UP:    status_d = pdUpPulse;
                fpsm_pkg::FPSM_S_DOWN:  status_d = pdDownPulse;
                default:                status_d = 1'b0;
            endcase
        end
    end

    // Status pin storage
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= 1'b0;
        end else begin
            status_q <= status_d;
        end
    end

    // Outputs
    assign regRdData       = rdData_q;
    assign prescalerOut    = prescOut_q;
    assign statusPin       = status_q;
    assign dualModulusMode = dmMode_q;
    assign statusSelect    = selReg_q[7:2];

endmodule : fpsm_top

// *** tb/fpsm_top_props.sv ***
`timescale 1ns/1ns
// Status mux and read data timing checks
module fpsm_top_props (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       nDivOut,
    input wire logic       rDivOut,
    input wire logic       aDivOut,
    input wire logic       pdUpPulse,
    input wire logic       pdDownPulse,
    input wire logic       sharedSelOut,
    input wire logic       prescalerOut,
    input wire logic       statusPin,
    input wire logic [5:0] statusSelect
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Selected source appears one cycle later
    property p_ndiv; statusSelect == 6'h01 |=> statusPin == $past(nDivOut); endproperty
    a_ndiv: assert property (p_ndiv) else $error("status pin not N output");
    property p_rdiv; statusSelect == 6'h02 |=> statusPin == $past(rDivOut); endproperty
    a_rdiv: assert property (p_rdiv) else $error("status pin not R output");
    property p_adiv; statusSelect == 6'h03 |=> statusPin == $past(aDivOut); endproperty
    a_adiv: assert property (p_adiv) else $error("status pin not A output");
    property p_pre; statusSelect == 6'h04 |=> statusPin == $past(prescalerOut); endproperty
    a_pre: assert property (p_pre) else $error("status pin not prescaler");
    property p_up; statusSelect == 6'h05 |=> statusPin == $past(pdUpPulse); endproperty
    a_up: assert property (p_up) else $error("status pin not up pulse");
    property p_dn; statusSelect == 6'h06 |=> statusPin == $past(pdDownPulse); endproperty
    a_dn: assert property (p_dn) else $error("status pin not down pulse");
    // Unassigned low codes and code 0x20 hold ground
    property p_gnd; (!statusSelect[5] && (statusSelect == 6'h00 || statusSelect > 6'h06))
        || statusSelect == 6'h20 |=> !statusPin; endproperty
    a_gnd: assert property (p_gnd) else $error("status pin not grounded");
    property p_shr; statusSelect[5] && statusSelect != 6'h20 |=> statusPin == $past(sharedSelOut);
    endproperty
    a_shr: assert property (p_shr) else $error("shared decode not passed");
    // Read data holds between reads
    property p_hold; !regRdEn |=> $stable(regRdData); endproperty
    a_hold: assert property (p_hold) else $error("read data changed without read");
endmodule : fpsm_top_props
bind fpsm_top fpsm_top_props u_props (.clk_sys, .reset_n, .regRdEn, .regRdData, .nDivOut,
    .rDivOut, .aDivOut, .pdUpPulse, .pdDownPulse, .sharedSelOut, .prescalerOut, .statusPin,
    .statusSelect);

// *** tb/fpsm_top_tb.sv ***
`timescale 1ns/1ns
module fpsm_top_tb;
    logic       clk_sys, reset_n, regWrEn, regRdEn, aCountNonzero; // Clock, reset, strobes
    logic [9:0] regAddr;                                          // Register address
    logic [7:0] regWrData, regRdData;                             // Register data
    logic       nDivOut, rDivOut, aDivOut, pdUpPulse, pdDownPulse, sharedSelOut;
    logic       prescalerOut, statusPin, dualModulusMode, expPin; // Outputs, expectation
    logic [5:0] statusSelect, src;                                // Selection, source pattern
    int         mismatches = 0, total_checks = 0, cycles = 0, n1, n2;
    localparam int PER[8] = '{1, 2, 2, 4, 8, 16, 32, 3};         // Base period per code
    localparam logic [5:0] SELS[11] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
        6'h07, 6'h20, 6'h21, 6'h3F};
    fpsm_top uut (.clk_sys, .reset_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .aCountNonzero,
        .nDivOut, .rDivOut, .aDivOut, .pdUpPulse, .pdDownPulse, .sharedSelOut, .regRdData,
        .prescalerOut, .statusPin, .dualModulusMode, .statusSelect);
    // Sources follow one pattern word
    assign {nDivOut, rDivOut, aDivOut, pdUpPulse, pdDownPulse, sharedSelOut} = src;
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("ERROR %0t: timeout", $time);
            report_and_stop();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] want);
        total_checks++;
        if (got !== want) begin
            mismatches++;
            $display("ERROR %0t: got %h want %h", $time, got, want);
        end
    endtask : chk
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {regWrEn, regAddr, regWrData} = {1'b1, a, d};
        @(negedge clk_sys);
        regWrEn = 1'b0;
    endtask : wr
    task rd(input logic [9:0] a, input logic [7:0] want);
        @(negedge clk_sys);
        {regRdEn, regAddr} = {1'b1, a};
        @(negedge clk_sys);
        regRdEn = 1'b0;
        @(negedge clk_sys);
        chk(regRdData, want);
    endtask : rd
    // Cycles until next prescaler pulse
    task per(output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (prescalerOut !== 1'b1 && n < 99);
    endtask : per
    task report_and_stop;
        if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    initial begin
        {regWrEn, regRdEn, aCountNonzero, regAddr, regWrData, src, reset_n} = '0;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys) reset_n = 1'b1;
        rd(10'h016, 8'h06);
        rd(10'h017, 8'h00);
        rd(10'h3FF, 8'h00);
        chk({7'h00, dualModulusMode}, 8'h01);
        // Every prescaler code, A zero then nonzero
        for (int a = 0; a < 2; a++) begin
            for (int c = 0; c < 8; c++) begin
                wr(10'h016, 8'hF8 | 8'(c));
                aCountNonzero = a[0];
                per(n1); per(n1); per(n1); per(n2);
                chk(8'(n1 + n2), 8'(2 * PER[c] + ((a == 1 && c >= 2 && c <= 6) ? 1 : 0)));
                chk({7'h00, dualModulusMode}, (c >= 2 && c <= 6) ? 8'h01 : 8'h00);
            end
        end
        rd(10'h016, 8'h07);
        wr(10'h016, 8'h01);
        // Status codes 0 to 7, 0x20, 0x21 and 0x3F against toggling sources
        foreach (SELS[i]) begin
            wr(10'h017, {SELS[i], 2'b11});
            rd(10'h017, {SELS[i], 2'b00});
            chk({2'b00, statusSelect}, {2'b00, SELS[i]});
            for (int k = 0; k < 9; k++) begin
                @(negedge clk_sys);
                if (k > 0) chk({7'h00, statusPin}, {7'h00, expPin});
                src = 6'(k * 13 + i);
                case (SELS[i])
                    6'h01: expPin = src[5];
                    6'h02: expPin = src[4];
                    6'h03: expPin = src[3];
                    6'h04: expPin = prescalerOut;
                    6'h05: expPin = src[2];
                    6'h06: expPin = src[1];
                    6'h20: expPin = 1'b0;
                    default: expPin = SELS[i][5] & src[0];
                endcase
            end
        end
        // Guard bit blocks reselection
        wr(10'h01D, 8'h80);
        wr(10'h017, 8'h04);
        rd(10'h017, 8'hFC);
        rd(10'h01D, 8'h80);
        wr(10'h01D, 8'h00);
        wr(10'h017, 8'h04);
        rd(10'h017, 8'h04);
        report_and_stop();
    end
endmodule : fpsm_top_tb
